// File: inc/rtcb_time_bank_regs.svh
`ifndef RTCB_TIME_BANK_REGS_SVH
`define RTCB_TIME_BANK_REGS_SVH
// ****************************************
// register indices
// ****************************************
`define RTCB_IDX_SEC      8'h00
`define RTCB_IDX_SEC_ALM  8'h01
`define RTCB_IDX_MIN      8'h02
`define RTCB_IDX_MIN_ALM  8'h03
`define RTCB_IDX_HR       8'h04
`define RTCB_IDX_HR_ALM   8'h05
`define RTCB_IDX_WDAY     8'h06
`define RTCB_IDX_MDAY     8'h07
`define RTCB_IDX_MON      8'h08
`define RTCB_IDX_YR       8'h09
`define RTCB_IDX_CTLA     8'h0a
`define RTCB_IDX_CTLB     8'h0b
// ****************************************
// field positions
// ****************************************
`define RTCB_UIP_BIT      7
`define RTCB_INHIBIT_BIT  7
`define RTCB_CODING_BIT   2
`define RTCB_HFMT_BIT     1
// ****************************************
// reset values and codes
// ****************************************
`define RTCB_COUNT_RST    8'h00
`define RTCB_CTLB_RST     8'h00
`define RTCB_DIV_RST      3'h2
`define RTCB_DIV_RUN      3'h2
`define RTCB_DIV_STOP     3'h0
`define RTCB_RATE_RST     4'h0
`define RTCB_RATE_ALIAS1  4'h1
`define RTCB_RATE_ALIAS2  4'h2
`define RTCB_TAP_ALIAS1   4'h7
`define RTCB_TAP_ALIAS2   4'h8
// ****************************************
// counter ranges, binary
// ****************************************
`define RTCB_ZERO         7'h00
`define RTCB_ONE          7'h01
`define RTCB_MINSEC_MAX   7'h3b
`define RTCB_HR24_MAX     7'h17
`define RTCB_HR12_MAX     7'h0c
`define RTCB_WDAY_MAX     7'h07
`define RTCB_MON_MAX      7'h0c
`define RTCB_YR_MAX       7'h63
`define RTCB_MDAY_LONG    7'h1f
`define RTCB_MDAY_SHORT   7'h1e
`define RTCB_MDAY_FEB     7'h1c
`define RTCB_MDAY_LEAP    7'h1d
`define RTCB_MON_FEB      7'h02
`define RTCB_MON_APR      7'h04
`define RTCB_MON_JUN      7'h06
`define RTCB_MON_SEP      7'h09
`define RTCB_MON_NOV      7'h0b
// ****************************************
// timing
// ****************************************
`define RTCB_OSC_HZ       32768
`define RTCB_UIP_LEAD_US  244
`define RTCB_UIP_TICKS    ((`RTCB_UIP_LEAD_US * `RTCB_OSC_HZ + 999999) / 1000000)
`define RTCB_DIV_LAST     15'h7fff
`endif

// File: inc/rtcb_pkg.sv
package rtcb_pkg;
    typedef logic [7:0] rtcb_byte_t;
    typedef logic [6:0] rtcb_bin_t;
endpackage

// File: logic/rtcb_field_step.sv
`timescale 1ns/1ps
`default_nettype none
module rtcb_field_step
    import rtcb_pkg::*;
(
    input  wire logic [7:0] value_i,
    input  wire logic       binary_i,
    input  wire logic [6:0] lo_i,
    input  wire logic [6:0] hi_i,
    output logic      [7:0] next_o,
    output logic      [6:0] cur_bin_o,
    output logic      [6:0] next_bin_o,
    output logic            wrap_o
);
    rtcb_bin_t bcd_bin;
    // ****************************************
    // decode, step, encode
    // ****************************************
    assign bcd_bin    = 7'({3'h0, value_i[7:4]} * 7'd10 + {3'h0, value_i[3:0]});
    assign cur_bin_o  = binary_i ? value_i[6:0] : bcd_bin;
    assign wrap_o     = (cur_bin_o >= hi_i);
    assign next_bin_o = wrap_o ? lo_i : 7'(cur_bin_o + 7'h01);
    assign next_o     = binary_i ? {1'b0, next_bin_o}
                                 : {4'(next_bin_o / 7'd10), 4'(next_bin_o % 7'd10)};
endmodule // rtcb_field_step
`default_nettype wire

// File: logic/rtcb_alarm_match.sv
`timescale 1ns/1ps
`default_nettype none
module rtcb_alarm_match
    import rtcb_pkg::*;
(
    input  wire logic [7:0] alarm_i,
    input  wire logic [7:0] count_i,
    output logic            match_o
);
    assign match_o = (&alarm_i[7:6]) | (alarm_i == count_i);
endmodule // rtcb_alarm_match
`default_nettype wire

// File: logic/rtcb_time_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtcb_time_bank_regs.svh"
// Contract
// - seconds, minutes count 0 to 59
// - alarm top bits 11 always match
// - 12-hour coding, top bit afternoon
// - 24-hour coding 0 to 23
// - weekday holds 1 to 7
// - date holds 1 to 31
// - month holds 1 to 12
// - year holds 0 to 99
// - update flag reads 0 when inhibited
// - update flag leads update 244 us
// - divider field stops, runs, resets chain
// - rate 0000 resets, gives no pulses
// - rate codes tap outputs 2 to 14
// - codes 1, 2 alias 8, 9
// - one update each second when divider field is 010
// - inhibit bit suspends updates
// - coding bit selects BCD or binary
// - format bit selects 12 or 24 hour
module rtcb_time_bank
    import rtcb_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       osc_tick_i,
    input  wire logic       io_sel_data_i,
    input  wire logic       io_wr_i,
    input  wire logic       io_rd_i,
    input  wire logic [7:0] io_wdata_i,
    output logic      [7:0] io_rdata_o,
    output logic            periodic_o,
    output logic            update_done_o,
    output logic            alarm_match_o
);
    // ****************************************
    // state
    // ****************************************
    rtcb_byte_t  index_reg;
    rtcb_byte_t  seconds_count;
    rtcb_byte_t  seconds_alarm_one;
    rtcb_byte_t  minutes_count;
    rtcb_byte_t  minutes_alarm_one;
    rtcb_byte_t  hours_count;
    rtcb_byte_t  hours_alarm_one;
    rtcb_byte_t  weekday_count;
    rtcb_byte_t  month_day_count;
    rtcb_byte_t  month_count;
    rtcb_byte_t  year_count;
    rtcb_byte_t  control_register_b;
    logic [2:0]  divider_chain_select;
    logic [3:0]  periodic_rate_select;
    logic [14:0] divider;
    logic        update_pending;
    logic [3:0]  lead_ticks;
    // ****************************************
    // combinational
    // ****************************************
    logic        wr_data;
    logic        update_inhibit;
    logic        data_coding_select;
    logic        hour_format_select;
    logic        div_running;
    logic        uip_due;
    logic        update_go;
    logic [14:0] next_divider;
    logic [3:0]  tap;
    logic        sec_wrap;
    logic        min_wrap;
    logic        hr_wrap;
    logic        mday_wrap;
    logic        mon_wrap;
    logic        hr_carry;
    logic        hr_day;
    logic        day_carry;
    logic        mday_carry;
    logic        mon_carry;
    logic        time_wr;
    logic        all_match;
    rtcb_byte_t  sec_next;
    rtcb_byte_t  min_next;
    rtcb_byte_t  hr_step;
    rtcb_byte_t  hr_next;
    rtcb_byte_t  hr_in;
    rtcb_byte_t  wday_next;
    rtcb_byte_t  mday_next;
    rtcb_byte_t  mon_next;
    rtcb_byte_t  yr_next;
    rtcb_bin_t   hr_lo;
    rtcb_bin_t   hr_hi;
    rtcb_bin_t   hr_nbin;
    rtcb_bin_t   mon_bin;
    rtcb_bin_t   yr_bin;
    rtcb_bin_t   mday_max;
    rtcb_byte_t  alm_bytes [3];
    rtcb_byte_t  cnt_bytes [3];
    logic [2:0]  fld_match;

    assign wr_data            = io_wr_i & io_sel_data_i;
    assign time_wr            = wr_data & (index_reg <= `RTCB_IDX_YR);
    assign update_inhibit     = control_register_b[`RTCB_INHIBIT_BIT];
    assign data_coding_select = control_register_b[`RTCB_CODING_BIT];
    assign hour_format_select = control_register_b[`RTCB_HFMT_BIT];
    // ****************************************
    // divider chain
    // ****************************************
    // run decode
    assign div_running  = (divider_chain_select != `RTCB_DIV_STOP)
                        & (divider_chain_select[2:1] != 2'b11);
    assign next_divider = 15'(divider + 15'h0001);
    assign uip_due      = osc_tick_i & div_running
                        & (next_divider == 15'(`RTCB_DIV_LAST - 15'(`RTCB_UIP_TICKS)));
    assign update_go    = osc_tick_i & update_pending & ~update_inhibit
                        & (divider_chain_select == `RTCB_DIV_RUN)
                        & (divider == `RTCB_DIV_LAST);

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            divider <= 15'h0000;
        end else if (divider_chain_select[2:1] == 2'b11) begin
            divider <= 15'h0000;
        end else if (osc_tick_i && div_running) begin
            divider <= next_divider;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            update_pending <= 1'b0;
        end else if (update_inhibit || divider_chain_select != `RTCB_DIV_RUN) begin
            update_pending <= 1'b0;
        end else if (osc_tick_i && divider == `RTCB_DIV_LAST) begin
            update_pending <= 1'b0;
        end else if (uip_due && !update_pending) begin
            update_pending <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lead_ticks <= 4'h0;
        end else if (!update_pending) begin
            lead_ticks <= 4'h0;
        end else if (osc_tick_i && lead_ticks != 4'hf) begin
            lead_ticks <= 4'(lead_ticks + 4'h1);
        end
    end

    // ****************************************
    // periodic rate
    // ****************************************
    // low code alias
    always_comb begin
        case (periodic_rate_select)
            `RTCB_RATE_ALIAS1: tap = `RTCB_TAP_ALIAS1;
            `RTCB_RATE_ALIAS2: tap = `RTCB_TAP_ALIAS2;
            default:           tap = 4'(periodic_rate_select - 4'h1);
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            periodic_o <= 1'b0;
        end else begin
            periodic_o <= osc_tick_i && div_running
                          && (periodic_rate_select != `RTCB_RATE_RST)
                          && ((next_divider & ~(15'h7fff << tap)) == 15'h0000);
        end
    end

    // ****************************************
    // field steppers
    // ****************************************
    // seconds range
    rtcb_field_step u_sec (
        .value_i    (seconds_count),
        .binary_i   (data_coding_select),
        .lo_i       (`RTCB_ZERO),
        .hi_i       (`RTCB_MINSEC_MAX),
        .next_o     (sec_next),
        .cur_bin_o  (),
        .next_bin_o (),
        .wrap_o     (sec_wrap)
    );

    rtcb_field_step u_min (
        .value_i    (minutes_count),
        .binary_i   (data_coding_select),
        .lo_i       (`RTCB_ZERO),
        .hi_i       (`RTCB_MINSEC_MAX),
        .next_o     (min_next),
        .cur_bin_o  (),
        .next_bin_o (),
        .wrap_o     (min_wrap)
    );

    assign hr_in = hour_format_select ? hours_count : {1'b0, hours_count[6:0]};
    assign hr_lo = hour_format_select ? `RTCB_ZERO : `RTCB_ONE;
    assign hr_hi = hour_format_select ? `RTCB_HR24_MAX : `RTCB_HR12_MAX;

    rtcb_field_step u_hr (
        .value_i    (hr_in),
        .binary_i   (data_coding_select),
        .lo_i       (hr_lo),
        .hi_i       (hr_hi),
        .next_o     (hr_step),
        .cur_bin_o  (),
        .next_bin_o (hr_nbin),
        .wrap_o     (hr_wrap)
    );

    assign hr_next = hour_format_select ? hr_step
        : {hours_count[7] ^ (hr_nbin == `RTCB_HR12_MAX), hr_step[6:0]};
    assign hr_day  = hour_format_select ? hr_wrap
        : (hours_count[7] & (hr_nbin == `RTCB_HR12_MAX));

    rtcb_field_step u_wday (
        .value_i    (weekday_count),
        .binary_i   (data_coding_select),
        .lo_i       (`RTCB_ONE),
        .hi_i       (`RTCB_WDAY_MAX),
        .next_o     (wday_next),
        .cur_bin_o  (),
        .next_bin_o (),
        .wrap_o     ()
    );

    always_comb begin
        case (mon_bin)
            `RTCB_MON_FEB: mday_max = (yr_bin[1:0] == 2'b00) ? `RTCB_MDAY_LEAP
                                                               : `RTCB_MDAY_FEB;
            `RTCB_MON_APR,
            `RTCB_MON_JUN,
            `RTCB_MON_SEP,
            `RTCB_MON_NOV: mday_max = `RTCB_MDAY_SHORT;
            default:       mday_max = `RTCB_MDAY_LONG;
        endcase
    end

    rtcb_field_step u_mday (
        .value_i    (month_day_count),
        .binary_i   (data_coding_select),
        .lo_i       (`RTCB_ONE),
        .hi_i       (mday_max),
        .next_o     (mday_next),
        .cur_bin_o  (),
        .next_bin_o (),
        .wrap_o     (mday_wrap)
    );

    rtcb_field_step u_mon (
        .value_i    (month_count),
        .binary_i   (data_coding_select),
        .lo_i       (`RTCB_ONE),
        .hi_i       (`RTCB_MON_MAX),
        .next_o     (mon_next),
        .cur_bin_o  (mon_bin),
        .next_bin_o (),
        .wrap_o     (mon_wrap)
    );

    rtcb_field_step u_yr (
        .value_i    (year_count),
        .binary_i   (data_coding_select),
        .lo_i       (`RTCB_ZERO),
        .hi_i       (`RTCB_YR_MAX),
        .next_o     (yr_next),
        .cur_bin_o  (yr_bin),
        .next_bin_o (),
        .wrap_o     ()
    );

    assign hr_carry   = sec_wrap & min_wrap;
    assign day_carry  = hr_carry & hr_day;
    assign mday_carry = day_carry & mday_wrap;
    assign mon_carry  = mday_carry & mon_wrap;

    // ****************************************
    // timekeeping counters
    // ****************************************
    // update and host write
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            seconds_count   <= `RTCB_COUNT_RST;
            minutes_count   <= `RTCB_COUNT_RST;
            hours_count     <= `RTCB_COUNT_RST;
            weekday_count   <= `RTCB_COUNT_RST;
            month_day_count <= `RTCB_COUNT_RST;
            month_count     <= `RTCB_COUNT_RST;
            year_count      <= `RTCB_COUNT_RST;
        end else begin
            if (update_go) begin
                seconds_count <= sec_next;
                if (sec_wrap)
                    minutes_count <= min_next;
                if (hr_carry)
                    hours_count <= hr_next;
                if (day_carry) begin
                    weekday_count   <= wday_next;
                    month_day_count <= mday_next;
                end
                if (mday_carry)
                    month_count <= mon_next;
                if (mon_carry)
                    year_count <= yr_next;
            end
            if (wr_data) begin
                case (index_reg)
                    `RTCB_IDX_SEC:  seconds_count   <= io_wdata_i;
                    `RTCB_IDX_MIN:  minutes_count   <= io_wdata_i;
                    `RTCB_IDX_HR:   hours_count     <= io_wdata_i;
                    `RTCB_IDX_WDAY: weekday_count   <= io_wdata_i;
                    `RTCB_IDX_MDAY: month_day_count <= io_wdata_i;
                    `RTCB_IDX_MON:  month_count     <= io_wdata_i;
                    `RTCB_IDX_YR:   year_count      <= io_wdata_i;
                    default: ;
                endcase
            end
        end
    end

    // ****************************************
    // host registers
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            index_reg            <= `RTCB_COUNT_RST;
            seconds_alarm_one    <= `RTCB_COUNT_RST;
            minutes_alarm_one    <= `RTCB_COUNT_RST;
            hours_alarm_one      <= `RTCB_COUNT_RST;
            control_register_b   <= `RTCB_CTLB_RST;
            divider_chain_select <= `RTCB_DIV_RST;
            periodic_rate_select <= `RTCB_RATE_RST;
        end else if (io_wr_i && !io_sel_data_i) begin
            index_reg <= io_wdata_i;
        end else if (wr_data) begin
            case (index_reg)
                `RTCB_IDX_SEC_ALM: seconds_alarm_one  <= io_wdata_i;
                `RTCB_IDX_MIN_ALM: minutes_alarm_one  <= io_wdata_i;
                `RTCB_IDX_HR_ALM:  hours_alarm_one    <= io_wdata_i;
                `RTCB_IDX_CTLB:    control_register_b <= io_wdata_i;
                `RTCB_IDX_CTLA: begin
                    divider_chain_select <= io_wdata_i[6:4];
                    periodic_rate_select <= io_wdata_i[3:0];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            io_rdata_o <= 8'h00;
        end else if (io_rd_i && !io_sel_data_i) begin
            io_rdata_o <= index_reg;
        end else if (io_rd_i) begin
            case (index_reg)
                `RTCB_IDX_SEC:     io_rdata_o <= seconds_count;
                `RTCB_IDX_SEC_ALM: io_rdata_o <= seconds_alarm_one;
                `RTCB_IDX_MIN:     io_rdata_o <= minutes_count;
                `RTCB_IDX_MIN_ALM: io_rdata_o <= minutes_alarm_one;
                `RTCB_IDX_HR:      io_rdata_o <= hours_count;
                `RTCB_IDX_HR_ALM:  io_rdata_o <= hours_alarm_one;
                `RTCB_IDX_WDAY:    io_rdata_o <= weekday_count;
                `RTCB_IDX_MDAY:    io_rdata_o <= month_day_count;
                `RTCB_IDX_MON:     io_rdata_o <= month_count;
                `RTCB_IDX_YR:      io_rdata_o <= year_count;
                `RTCB_IDX_CTLA:    io_rdata_o <= {update_pending & ~update_inhibit,
                                                  divider_chain_select,
                                                  periodic_rate_select};
                `RTCB_IDX_CTLB:    io_rdata_o <= control_register_b;
                default:           io_rdata_o <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // alarm compare
    // ****************************************
    assign alm_bytes[0] = seconds_alarm_one;
    assign alm_bytes[1] = minutes_alarm_one;
    assign alm_bytes[2] = hours_alarm_one;
    assign cnt_bytes[0] = seconds_count;
    assign cnt_bytes[1] = minutes_count;
    assign cnt_bytes[2] = hours_count;

    for (genvar g = 0; g < 3; g++) begin : g_alm
        rtcb_alarm_match u_match (
            .alarm_i (alm_bytes[g]),
            .count_i (cnt_bytes[g]),
            .match_o (fld_match[g])
        );
    end
    assign all_match = &fld_match;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            update_done_o <= 1'b0;
            alarm_match_o <= 1'b0;
        end else begin
            update_done_o <= update_go;
            alarm_match_o <= update_done_o & all_match;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    a_sec_wrap: assert property (
        update_go && !data_coding_select && seconds_count == 8'h59 && !time_wr
        |=> seconds_count == 8'h00) else $error("seconds did not wrap");
    a_alarm_dontcare: assert property (
        update_done_o && (&seconds_alarm_one[7:6]) && (&minutes_alarm_one[7:6])
        && (&hours_alarm_one[7:6]) |=> alarm_match_o) else $error("dont care missed");
    a_hour_pm: assert property (
        update_go && hr_carry && !data_coding_select && !hour_format_select
        && hours_count == 8'h11 && !time_wr |=> hours_count == 8'h92)
        else $error("noon not marked afternoon");
    a_hour_24: assert property (
        update_go && hr_carry && !data_coding_select && hour_format_select
        && hours_count == 8'h23 && !time_wr |=> hours_count == 8'h00)
        else $error("24 hour wrap wrong");
    a_wday_wrap: assert property (
        update_go && day_carry && weekday_count == 8'h07 && !time_wr
        |=> weekday_count == 8'h01) else $error("weekday wrap wrong");
    a_mday_wrap: assert property (
        update_go && day_carry && !data_coding_select && month_day_count == 8'h31
        && !time_wr |=> month_day_count == 8'h01) else $error("date wrap wrong");
    a_month_wrap: assert property (
        update_go && mday_carry && !data_coding_select && month_count == 8'h12
        && !time_wr |=> month_count == 8'h01) else $error("month wrap wrong");
    a_year_wrap: assert property (
        update_go && mon_carry && data_coding_select && year_count == 8'h63
        && !time_wr |=> year_count == 8'h00) else $error("year wrap wrong");
    a_uip_inhibit: assert property (
        io_rd_i && io_sel_data_i && index_reg == `RTCB_IDX_CTLA && update_inhibit
        |=> !io_rdata_o[`RTCB_UIP_BIT]) else $error("flag set while inhibited");
    a_uip_lead: assert property (
        update_go |-> lead_ticks >= 4'(`RTCB_UIP_TICKS)) else $error("lead too short");
    a_div_reset: assert property (
        divider_chain_select[2:1] == 2'b11 |=> divider == 15'h0000)
        else $error("divider not held");
    a_rate_off: assert property (
        periodic_rate_select == `RTCB_RATE_RST |=> !periodic_o)
        else $error("pulse with rate off");
    a_update_second: assert property (
        update_go |-> divider == `RTCB_DIV_LAST
        && divider_chain_select == `RTCB_DIV_RUN) else $error("update off second");
    a_inhibit_hold: assert property (
        update_inhibit |-> !update_go ##1 !update_done_o) else $error("update inhibited");
endmodule // rtcb_time_bank
`default_nettype wire

// File: verification/rtcb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host side of the index/data port
// ****************************************
module rtcb_host_model (
    input  wire logic       clk_i,
    output logic            sel_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic      [7:0] wdata_o
);
    initial begin
        sel_o = 1'b0;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end
    // one strobe cycle, data scrambled once released
    task automatic put(input logic sel, input logic wr, input logic [7:0] d);
        @(negedge clk_i);
        sel_o = sel;
        wr_o = wr;
        rd_o = !wr;
        wdata_o = d;
        @(negedge clk_i);
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = ~d;
    endtask
endmodule // rtcb_host_model
`default_nettype wire

// File: verification/rtcb_time_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rtcb_time_bank_tb;
    import rtcb_pkg::*;
    logic        ref_clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        osc_tick_i = 1'b0;
    logic        tick_en = 1'b0;
    logic        sel, wr, rd, periodic, upd, alm;
    logic  [7:0] wdata, rdata;
    int          miscompares = 0;
    int          num_checks = 0;
    int          alarms = 0;
    int          updates = 0;
    int          y;
    logic [31:0] seed = 32'd21;
    rtcb_byte_t  expq[$];
    rtcb_time_bank i_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .osc_tick_i(osc_tick_i),
        .io_sel_data_i(sel), .io_wr_i(wr), .io_rd_i(rd), .io_wdata_i(wdata),
        .io_rdata_o(rdata), .periodic_o(periodic), .update_done_o(upd),
        .alarm_match_o(alm));
    rtcb_host_model i_host (.clk_i(ref_clk_i), .sel_o(sel), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
    initial begin
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    always @(negedge ref_clk_i) osc_tick_i <= tick_en;
    always @(posedge ref_clk_i) if (alm === 1'b1) alarms++;
    always @(posedge ref_clk_i) if (upd === 1'b1) updates++;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wr_reg(input rtcb_byte_t idx, input rtcb_byte_t d);
        i_host.put(1'b0, 1'b1, idx);
        i_host.put(1'b1, 1'b1, d);
    endtask
    task automatic rd_reg(input rtcb_byte_t idx, input rtcb_byte_t exp);
        i_host.put(1'b0, 1'b1, idx);
        expq.push_back(exp);
        i_host.put(1'b1, 1'b0, 8'h00);
    endtask
    // one tick per cycle, so a pulse interval in cycles is the divider period
    task automatic rate_period(input logic [3:0] code, input logic [15:0] exp);
        int n;
        wr_reg(8'h0a, {4'h2, code});
        n = 0;
        @(negedge ref_clk_i);
        while (periodic !== 1'b1 && n < 20000) begin
            @(negedge ref_clk_i);
            n++;
        end
        n = 0;
        do begin
            @(negedge ref_clk_i);
            n++;
        end while (periodic !== 1'b1 && n < 20000);
        check("periodic cycles", 16'(n), exp);
    endtask
    // ****************************************
    // read monitor, oldest note first
    // ****************************************
    always @(posedge ref_clk_i) begin
        if (rd === 1'b1) begin
            repeat (2) @(negedge ref_clk_i);
            check("read data", rdata, expq.pop_front());
        end
    end
    initial begin
        #400000;
        miscompares++;
        finish_test();
    end
    initial begin
        repeat (3) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        resetn_i = 1'b1;
        for (int i = 0; i < 10; i++) rd_reg(i[7:0], 8'h00);
        rd_reg(8'h0a, 8'h20);
        rd_reg(8'h0c, 8'h00);
        $display("test reset values done");
        wr_reg(8'h00, 8'h59);
        wr_reg(8'h02, 8'h59);
        wr_reg(8'h04, 8'h11);
        for (int i = 1; i < 6; i += 2) wr_reg(i[7:0], 8'hc0);
        seed = xs(seed);
        y = int'(seed % 100);
        wr_reg(8'h09, rtcb_byte_t'((y / 10) * 16 + y % 10));
        tick_en = 1'b1;
        for (int n = 0; n < 40000 && upd !== 1'b1; n++) @(posedge ref_clk_i);
        repeat (4) @(negedge ref_clk_i);
        tick_en = 1'b0;
        rd_reg(8'h00, 8'h00);
        rd_reg(8'h02, 8'h00);
        rd_reg(8'h04, 8'h92);
        rd_reg(8'h09, rtcb_byte_t'((y / 10) * 16 + y % 10));
        check("alarm pulses", rtcb_byte_t'(alarms), 8'h01);
        check("update pulses", 16'(updates), 16'h0001);
        $display("test rollover and alarm done");
        wr_reg(8'h0b, 8'h80);
        tick_en = 1'b1;
        repeat (33000) @(negedge ref_clk_i);
        rd_reg(8'h0a, 8'h20);
        rd_reg(8'h00, 8'h00);
        rd_reg(8'h0b, 8'h80);
        repeat (4) @(negedge ref_clk_i);
        check("update pulses", 16'(updates), 16'h0001);
        $display("test inhibit done");
        rate_period(4'h3, 16'h0004);
        rate_period(4'ha, 16'h0200);
        rate_period(4'h1, 16'h0080);
        rate_period(4'h2, 16'h0100);
        $display("test periodic rate done");
        finish_test();
    end
endmodule // rtcb_time_bank_tb
`default_nettype wire
